// File: core/lib_exec_pkg.sv
// Shared constants for the loop, increment and branch execution unit
package lib_exec_pkg;
   // Opcodes handled by this unit
   localparam logic [7:0] OP_LOOP_REG_BASE = 8'hD8;  // 11011rrr
   localparam logic [7:0] OP_LOOP_DIRECT   = 8'hD5;
   localparam logic [7:0] OP_INC_ACC       = 8'h04;
   localparam logic [7:0] OP_INC_DIRECT    = 8'h05;
   localparam logic [7:0] OP_INC_IND_BASE  = 8'h06;  // 0000011i
   localparam logic [7:0] OP_INC_REG_BASE  = 8'h08;  // 00001rrr
   localparam logic [7:0] OP_INC_POINTER   = 8'hA3;
   localparam logic [7:0] OP_JUMP_BIT_SET  = 8'h20;
   localparam logic [7:0] OP_JUMP_BIT_CLR  = 8'h10;
   localparam logic [7:0] OP_JUMP_NO_BIT   = 8'h30;
   localparam logic [7:0] OP_JUMP_CARRY    = 8'h40;
   localparam logic [7:0] OP_TABLE_JUMP    = 8'h73;
   // Reset values
   localparam logic [15:0] PC_RESET    = 16'h0000;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   // Machine cycle counts
   localparam int unsigned CYCLES_LONG  = 2;
   localparam int unsigned CYCLES_SHORT = 1;
   // Unit phases, one-hot
   typedef enum logic [4:0] {
      PH_OPCODE  = 5'b00001,
      PH_BYTE2   = 5'b00010,
      PH_BYTE3   = 5'b00100,
      PH_EXEC    = 5'b01000,
      PH_PAD     = 5'b10000
   } phase_t;
endpackage

// File: core/lib_byte_mem.sv
// Small byte memory with registered read data, for the data space
`timescale 1ns/1ps
`default_nettype none
module lib_byte_mem #(
   parameter int unsigned DEPTH = 256
) (
   // Clock
   input  wire logic       clock,
   // Write port
   input  wire logic       writeEn,
   input  wire logic [7:0] writeAddr,
   input  wire logic [7:0] writeData,
   // Read port
   input  wire logic [7:0] readAddr,
   output logic      [7:0] readData
);
   // Storage array, no reset so it maps to RAM
   logic [7:0] store [DEPTH];

   // Write and registered read; read sees the old value on collision
   always_ff @(posedge clock) begin
      if (writeEn) begin
         store[writeAddr] <= writeData;
      end
      readData <= store[readAddr];
   end
endmodule
`default_nettype wire

// File: core/loop_increment_branch_exec.sv
// Execution unit for decrement-loop, increment and relative branches
// Summary of operation
// RULE_01: decrement wraps, branch if nonzero, flags kept
// RULE_02: target is advanced counter plus last displacement
// RULE_03: port operands read from output latch
// RULE_04: register loop form 11011rrr, two bytes
// RULE_05: direct loop form D5, three bytes
// RULE_06: increment wraps FF to 00, flags kept
// RULE_07: direct increment is opcode 05, two bytes
// RULE_08: pointer pair 16-bit increment, two cycles
// RULE_09: jump bit set, third byte displacement
// RULE_10: jump bit set clears bit when taken
// RULE_11: jump carry set, second byte displacement
// RULE_12: table jump loads accumulator plus pointer
// RULE_13: table jump one byte, two cycles
// RULE_14: jump bit clear, bit unchanged
// RULE_15: loop delay spans 2 to 512 cycles
// RULE_16: displacement sign-extended, added modulo 2^16
// RULE_17: untaken branch still takes full cycles
`timescale 1ns/1ps
`default_nettype none
module loop_increment_branch_exec
   import lib_exec_pkg::*;
#(
   parameter int unsigned MEM_DEPTH = 256
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // Program memory; byte for progAddr is taken in the same cycle
   output logic      [15:0] progAddr,
   input  wire logic [7:0]  progData,
   // Processor state inputs
   input  wire logic        carryFlag,
   input  wire logic [7:0]  portLatch,
   // Architectural state visible to the core
   output logic      [15:0] programCounter,
   output logic      [7:0]  accumulator,
   output logic      [15:0] dataPointerPair,
   output logic      [7:0]  bitSpace,
   // Execution status
   output logic             opcodeFetch,
   output logic             unknownOpcode
);
   // Whole unit state in one record
   typedef struct packed {
      phase_t      phase;
      logic [15:0] pc;
      logic [7:0]  acc;
      logic [15:0] ptrPair;
      logic [7:0]  bits;      // Bit-addressable byte, bits 0..7
      logic [7:0][7:0] regs;  // Packed so the whole record stays packed
      logic [7:0]  opcode;
      logic [7:0]  operand;   // Direct or bit address
      logic [7:0]  disp;
      logic        bad;
   } state_t;

   state_t cur;       // Registered state
   state_t next_cur;  // Next state

   // Data memory for direct and indirect bytes
   logic       memWe;
   logic [7:0] memWaddr;
   logic [7:0] memWdata;
   logic [7:0] memRaddr;
   logic [7:0] memRdata;

   // Port latch sits at this direct address; reads take the latch
   localparam logic [7:0] PORT_ADDR = 8'h90;

   lib_byte_mem #(.DEPTH(MEM_DEPTH)) dataMem (
      .clock     (clock),
      .writeEn   (memWe),
      .writeAddr (memWaddr),
      .writeData (memWdata),
      .readAddr  (memRaddr),
      .readData  (memRdata)
   );

   // Relative target, shared by every conditional branch
   function automatic logic [15:0] relTarget(input logic [15:0] pc,
                                              input logic [7:0]  d);
      // RULE_16 sign extend
      relTarget = pc + {{8{d[7]}}, d};
   endfunction

   // Opcode length in bytes
   function automatic logic [1:0] opLength(input logic [7:0] op);
      if (op[7:3] == OP_LOOP_REG_BASE[7:3] || op == OP_INC_DIRECT ||
          op == OP_JUMP_CARRY) begin
         opLength = 2'd2;
      end else if (op == OP_LOOP_DIRECT || op == OP_JUMP_BIT_SET ||
                   op == OP_JUMP_BIT_CLR || op == OP_JUMP_NO_BIT) begin
         opLength = 2'd3;
      end else begin
         opLength = 2'd1;
      end
   endfunction

   // Increment forms; all but indirect and pointer increment finish without the pad phase
   function automatic logic isShort(input logic [7:0] op);
      isShort = op == OP_INC_ACC || op == OP_INC_DIRECT ||
                op[7:1] == OP_INC_IND_BASE[7:1] ||
                op[7:3] == OP_INC_REG_BASE[7:3];
   endfunction

   // Operand read value, port latch substituted
   logic [7:0] memValue;
   always_comb begin
      // RULE_03 latch not pins
      memValue = (cur.operand == PORT_ADDR) ? portLatch : memRdata;
   end

   // Next state logic
   always_comb begin
      logic [7:0] res;
      logic       taken;
      logic       bitVal;
      res      = BYTE_RESET;
      taken    = 1'b0;
      bitVal   = cur.bits[cur.operand[2:0]];
      next_cur = cur;
      memWe    = 1'b0;
      memWaddr = cur.operand;
      memWdata = BYTE_RESET;
      memRaddr = cur.operand;
      case (cur.phase)
         // Take opcode, step counter
         PH_OPCODE: begin
            next_cur.opcode = progData;
            next_cur.pc     = cur.pc + 16'h0001;
            next_cur.bad    = 1'b0;
            if (opLength(progData) == 2'd1) begin
               next_cur.phase = PH_EXEC;
            end else begin
               next_cur.phase = PH_BYTE2;
            end
         end
         // Second byte is address or displacement
         PH_BYTE2: begin
            next_cur.pc = cur.pc + 16'h0001;
            if (opLength(cur.opcode) == 2'd3 ||
                cur.opcode == OP_INC_DIRECT) begin
               next_cur.operand = progData;
               memRaddr         = progData;
            end else begin
               next_cur.disp = progData;
            end
            if (opLength(cur.opcode) == 2'd3) begin
               next_cur.phase = PH_BYTE3;
            end else begin
               next_cur.phase = PH_EXEC;
            end
         end
         // Third byte is displacement
         PH_BYTE3: begin
            // RULE_02 counter past whole instruction
            next_cur.pc    = cur.pc + 16'h0001;
            next_cur.disp  = progData;
            next_cur.phase = PH_EXEC;
         end
         // Perform the operation
         PH_EXEC: begin
            next_cur.phase = isShort(cur.opcode) ? PH_OPCODE : PH_PAD;
            if (cur.opcode[7:3] == OP_LOOP_REG_BASE[7:3]) begin
               // RULE_04 register loop
               // RULE_01 wrap and test
               res = cur.regs[cur.opcode[2:0]] - 8'h01;
               next_cur.regs[cur.opcode[2:0]] = res;
               taken = res != BYTE_RESET;
            end else if (cur.opcode == OP_LOOP_DIRECT) begin
               // RULE_05 direct loop
               res      = memValue - 8'h01;
               memWe    = 1'b1;
               memWdata = res;
               taken    = res != BYTE_RESET;
            end else if (cur.opcode == OP_INC_ACC) begin
               // RULE_06 wrap increment
               next_cur.acc = cur.acc + 8'h01;
            end else if (cur.opcode[7:3] == OP_INC_REG_BASE[7:3]) begin
               next_cur.regs[cur.opcode[2:0]] =
                  cur.regs[cur.opcode[2:0]] + 8'h01;
            end else if (cur.opcode == OP_INC_DIRECT) begin
               // RULE_07 direct increment
               memWe    = 1'b1;
               memWdata = memValue + 8'h01;
            end else if (cur.opcode[7:1] == OP_INC_IND_BASE[7:1]) begin
               // Indirect increment needs one read cycle first
               next_cur.operand = cur.regs[{2'b00, cur.opcode[0]}];
               // Read the pointed byte now so it stands in the pad cycle
               memRaddr         = cur.regs[{2'b00, cur.opcode[0]}];
               next_cur.phase   = PH_PAD;
            end else if (cur.opcode == OP_INC_POINTER) begin
               // RULE_08 sixteen bit carry
               next_cur.ptrPair = cur.ptrPair + 16'h0001;
            end else if (cur.opcode == OP_JUMP_BIT_SET) begin
               // RULE_09 branch on one
               taken = bitVal;
            end else if (cur.opcode == OP_JUMP_BIT_CLR) begin
               // RULE_10 clear only when set
               taken = bitVal;
               if (bitVal) begin
                  next_cur.bits[cur.operand[2:0]] = 1'b0;
               end
            end else if (cur.opcode == OP_JUMP_NO_BIT) begin
               // RULE_14 branch on zero
               taken = !bitVal;
            end else if (cur.opcode == OP_JUMP_CARRY) begin
               // RULE_11 branch on carry
               taken = carryFlag;
            end else if (cur.opcode == OP_TABLE_JUMP) begin
               // RULE_12 unsigned sum
               // RULE_13 single byte
               next_cur.pc = cur.ptrPair + {8'h00, cur.acc};
            end else begin
               next_cur.bad   = 1'b1;
               next_cur.phase = PH_OPCODE;
            end
            if (taken) begin
               next_cur.pc = relTarget(cur.pc, cur.disp);
            end
         end
         // Second machine cycle, or indirect write-back
         PH_PAD: begin
            // RULE_17 full count kept
            // RULE_15 two cycles per loop pass
            next_cur.phase = PH_OPCODE;
            if (cur.opcode[7:1] == OP_INC_IND_BASE[7:1]) begin
               memWe    = 1'b1;
               memWdata = memValue + 8'h01;
            end
         end
         default: begin
            next_cur.phase = PH_OPCODE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cur.phase   <= PH_OPCODE;
         cur.pc      <= PC_RESET;
         cur.acc     <= BYTE_RESET;
         cur.ptrPair <= PC_RESET;
         cur.bits    <= BYTE_RESET;
         cur.regs    <= '0;
         cur.opcode  <= BYTE_RESET;
         cur.operand <= BYTE_RESET;
         cur.disp    <= BYTE_RESET;
         cur.bad     <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs
   assign progAddr        = cur.pc;
   assign programCounter  = cur.pc;
   assign accumulator     = cur.acc;
   assign dataPointerPair = cur.ptrPair;
   assign bitSpace        = cur.bits;
   assign opcodeFetch     = cur.phase == PH_OPCODE;
   assign unknownOpcode   = cur.bad;

   // Checks
   // RULE_08 pointer step
   chk_ptr_inc: assert property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_INC_POINTER
      |=> cur.ptrPair == $past(cur.ptrPair) + 16'h0001)
      else $error("pointer increment wrong");
   // RULE_12 table jump target
   chk_table_jump: assert property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_TABLE_JUMP
      |=> cur.pc == $past(cur.ptrPair) + {8'h00, $past(cur.acc)})
      else $error("table jump target wrong");
   // RULE_10 bit cleared when taken
   chk_bit_clear: assert property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_JUMP_BIT_CLR
      |=> cur.bits[$past(cur.operand[2:0])] == 1'b0)
      else $error("bit not cleared");
   // RULE_14 bit unchanged
   chk_bit_keep: assert property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_JUMP_NO_BIT
      |=> $stable(cur.bits))
      else $error("bit changed");
   // RULE_17 carry branch pads once
   chk_two_cycle: assert property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_JUMP_CARRY
      |=> cur.phase == PH_PAD ##1 cur.phase == PH_OPCODE)
      else $error("cycle count wrong");
   // RULE_11 carry branch target
   chk_carry_jump: assert property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_JUMP_CARRY && carryFlag
      |=> cur.pc == $past(cur.pc) + {{8{$past(cur.disp[7])}},
                                      $past(cur.disp)})
      else $error("carry branch wrong");
   // RULE_09 not taken stays
   chk_bit_set: assert property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_JUMP_BIT_SET &&
      !cur.bits[cur.operand[2:0]] |=> $stable(cur.pc))
      else $error("bit branch taken wrongly");
   // RULE_06 accumulator increment
   chk_acc_inc: assert property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_INC_ACC
      |=> cur.acc == $past(cur.acc) + 8'h01 && cur.phase == PH_OPCODE)
      else $error("accumulator increment wrong");
   cov_loop: cover property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode[7:3] == OP_LOOP_REG_BASE[7:3]);
   cov_table: cover property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_TABLE_JUMP);
   cov_bit_clear: cover property (@(posedge clock) disable iff (!arst_n)
      cur.phase == PH_EXEC && cur.opcode == OP_JUMP_BIT_CLR);
endmodule
`default_nettype wire

// File: dv/prog_mem_model.sv
// Program memory model answering the fetch address without delay
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   // Fetch port
   input  wire logic [15:0] progAddr,
   output logic      [7:0]  progData
);
   // Full code space, loaded by the bench before each run
   logic [7:0] mem [0:65535];
   // Byte stands as long as its address is shown, so no hold hazard
   assign progData = mem[progAddr];
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the loop, increment and branch unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import lib_exec_pkg::*;
;
   // Design connections
   logic        clock;
   logic        arst_n;
   logic        carryFlag;
   logic [7:0]  portLatch;
   logic [15:0] progAddr;
   logic [7:0]  progData;
   logic [15:0] programCounter;
   logic [7:0]  accumulator;
   logic [15:0] dataPointerPair;
   logic [7:0]  bitSpace;
   logic        opcodeFetch;
   logic        unknownOpcode;
   // Bench bookkeeping
   int          miscompares;
   int          n_tests;
   int          cyc;
   int          tjCyc;
   int          n;

   loop_increment_branch_exec loop_increment_branch_exec_i (
      .clock(clock), .arst_n(arst_n), .progAddr(progAddr),
      .progData(progData), .carryFlag(carryFlag), .portLatch(portLatch),
      .programCounter(programCounter), .accumulator(accumulator),
      .dataPointerPair(dataPointerPair), .bitSpace(bitSpace),
      .opcodeFetch(opcodeFetch), .unknownOpcode(unknownOpcode));
   prog_mem_model prog_mem_model_i (
      .progAddr(progAddr), .progData(progData));

   // Free-running 10 MHz clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Compare and count; values are widened to 16 bits by the caller
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
      end
   endtask

   // Single place where the run ends
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Reset with a code space of unsupported opcodes, held four cycles
   task automatic restart;
      arst_n = 1'b0;
      for (int a = 0; a < 65536; a++) begin
         prog_mem_model_i.mem[a] = 8'hA5;
      end
      repeat (4) @(negedge clock);
      arst_n = 1'b1;
   endtask

   // Place a byte string in code space
   task automatic load(input int base, input logic [7:0] q[$]);
      foreach (q[i]) begin
         prog_mem_model_i.mem[base + i] = q[i];
      end
   endtask

   // Run one instruction; c is clocks from opcode edge to next fetch
   task automatic step(output int c);
      int k;
      k = 0;
      while (opcodeFetch !== 1'b1 && k < 50) begin
         @(negedge clock);
         k++;
      end
      @(negedge clock);
      c = 1;
      while (opcodeFetch !== 1'b1 && c < 50) begin
         @(negedge clock);
         c++;
      end
      // A stuck unit never asks for the next opcode
      if (k >= 50 || c >= 50) begin
         miscompares++;
         report_and_stop();
      end
   endtask

   // Pointer and accumulator counted up, then the table jump
   task automatic test_table(input int nd, input int na);
      logic [15:0] d;
      logic [7:0]  a;
      d = nd[15:0];
      a = na[7:0];
      restart();
      for (int i = 0; i < nd; i++) load(i, {OP_INC_POINTER});
      for (int i = 0; i < na; i++) load(nd + i, {OP_INC_ACC});
      load(nd + na, {OP_TABLE_JUMP});
      for (int i = 0; i < nd + na; i++) step(cyc);
      check(dataPointerPair, d, "pointer count");
      check({8'h00, accumulator}, {8'h00, a}, "acc count");
      step(tjCyc);
      check(programCounter, d + {8'h00, a}, "table target");
      check(dataPointerPair, d, "pointer kept");
      check({8'h00, accumulator}, {8'h00, a}, "acc kept");
      $display("Test table %0d %0d done", nd, na);
   endtask

   // Carry branch, taken and not, against both displacement signs
   task automatic test_carry;
      logic [7:0]  disp [4] = '{8'h05, 8'hFC, 8'h80, 8'h7F};
      logic [15:0] exp;
      for (int c = 0; c < 2; c++) begin
         foreach (disp[i]) begin
            restart();
            carryFlag = c[0];
            load(0, {OP_JUMP_CARRY, disp[i]});
            step(cyc);
            exp = 16'h0002 + (c ? {{8{disp[i][7]}}, disp[i]} : 16'h0000);
            check(programCounter, exp, "carry branch");
            // Clocks seen: one per byte fetched plus the two cycles
            check(cyc[15:0], 16'(2 + CYCLES_LONG), "carry cycles");
         end
      end
      carryFlag = 1'b0;
      $display("Test carry done");
   endtask

   // Bit tests with every bit clear
   task automatic test_bits;
      int c1;
      restart();
      load(0, {OP_JUMP_BIT_SET, 8'h03, 8'h10, OP_JUMP_NO_BIT, 8'h03, 8'h10});
      load(16'h16, {OP_JUMP_BIT_CLR, 8'h07, 8'hF0});
      step(c1);
      check(programCounter, 16'h0003, "set not taken");
      step(cyc);
      check(programCounter, 16'h0016, "clear taken");
      check(cyc[15:0], c1[15:0], "bit cycles");
      step(cyc);
      check(programCounter, 16'h0019, "set clear idle");
      check({8'h00, bitSpace}, 16'h0000, "bits kept");
      // Filler byte is unsupported: flagged, counter steps by one
      step(cyc);
      check({15'h0000, unknownOpcode}, 16'h0001, "refused");
      check(programCounter, 16'h001A, "refused step");
      $display("Test bits done");
   endtask

   // Direct loop on the port address; value comes from the latch
   task automatic test_loop_port;
      logic [7:0] lat [3] = '{8'h00, 8'h80, 8'h01};
      restart();
      load(0, {OP_LOOP_DIRECT, 8'h90, 8'hFD});
      load(16'h90, {8'h00});
      foreach (lat[i]) begin
         portLatch = lat[i];
         step(cyc);
         // Only a latch of one counts down to zero and falls through
         check(programCounter, (lat[i] == 8'h01) ? 16'h0003 : 16'h0000,
               "loop on port");
         check(cyc[15:0], 16'(3 + CYCLES_LONG), "loop cycles");
      end
      check({8'h00, accumulator}, 16'h0000, "acc untouched");
      $display("Test loop port done");
   endtask

   // Main sequence
   initial begin
      arst_n = 1'b0;
      carryFlag = 1'b0;
      portLatch = 8'h00;
      miscompares = 0;
      n_tests = 0;
      test_table(256, 0);
      test_table(255, 1);
      test_table(0, 256);
      test_table(2, 255);
      test_carry();
      test_bits();
      test_loop_port();
      report_and_stop();
   end
endmodule
`default_nettype wire
